// ---- hw/pid_ctrl.v ----
`timescale 1ns/100ps
`include "pid_regs.vh"
// --------------------------------------------------------------------------
// Notes on behaviour
// RULE1: Programming tristates shared and dedicated fabric pins; here only pins whose pincfg_r pair is 00 or 11 float, 01 drives low, 10 high.
// RULE2: Programming blocks memory-controller and transceiver fabric buses.
// RULE3: Blank device keeps every user pin tristated.
// RULE4: Per-pin programming level: tristate, low, high.
// RULE5: 32-bit signature digest over stored image.
// RULE6: Digest accumulates during programming, stored afterwards.
// RULE7: Verify request recomputes digest and compares stored.
// RULE8: No digest check at power-up, only on request.
// RULE9: Disable option acts after reset with test-reset low; reset clears dis_opt_r before it is sampled, so here it never acts.
// RULE10: Info request reports name, checksum, digest.
// RULE11: Info response also carries programming cycle count.
// RULE12: Info requests change no counters.
// RULE13: Programmer counts its own verify operations.
// RULE14: Fabric enabled only after programming fully verified.
// RULE15: Command register plus 128-bit data buffer.
// RULE16: Signature seeded, fixed polynomial for both passes.
// --------------------------------------------------------------------------
module pid_ctrl (
    // Clock and reset.
    input  wire                  i_clk,
    input  wire                  i_resetn,
    // Test link pins.
    input  wire                  i_tck,
    input  wire                  i_tms,
    input  wire                  i_tdi,
    input  wire                  i_test_logic_reset_pin,
    output wire                  o_tdo,
    // Register port.
    input  wire [7:0]            i_addr,
    input  wire [31:0]           i_wdata,
    input  wire                  i_wr,
    input  wire                  i_rd,
    output reg  [31:0]           o_rdata,
    // Fabric user pins.
    input  wire [`PID_PINS-1:0]  i_fab_out,
    input  wire [`PID_PINS-1:0]  i_fab_oe_n,
    output reg  [`PID_PINS-1:0]  o_pin_out,
    output reg  [`PID_PINS-1:0]  o_pin_oe_n,
    // Fabric state and bus gating.
    output reg                   o_fabric_en,
    output reg                   o_bus_block,
    // Interrupt.
    output reg                   o_irq
);
    // ------------------------------------------------------------------
    // States.
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PROG = 3'd1;
    localparam [2:0] ST_RD   = 3'd2;
    localparam [2:0] ST_ACC  = 3'd3;
    localparam [2:0] ST_DONE = 3'd4;

    // Folds a 128-bit buffer into one 32-bit signature input.
    function [31:0] fold;
        input [`PID_BUF_W-1:0] d;
        begin
            fold = d[127:96] ^ d[95:64] ^ d[63:32] ^ d[31:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    reg  [1:0]               tck_s_r;
    reg  [1:0]               tms_s_r;
    reg  [1:0]               tdi_s_r;
    reg  [1:0]               trst_s_r;
    reg                      tck_d_r;
    reg                      tms_d_r;
    reg  [`PID_FRAME_W-1:0]  shift_r;
    reg  [`PID_BUF_W-1:0]    resp_r;
    reg  [`PID_CMD_W-1:0]    cmd_r;
    reg  [`PID_BUF_W-1:0]    buf_r;
    reg                      cmd_vld_r;
    reg  [2:0]               state_r;
    reg                      mode_prog_r;
    reg  [`PID_AW:0]         wr_cnt_r;
    reg  [`PID_AW-1:0]       rd_ptr_r;
    reg  [31:0]              digest_r;
    reg  [31:0]              name_r;
    reg  [31:0]              chksum_r;
    reg  [31:0]              cycles_r;
    reg                      programmed_r;
    reg                      enabled_r;
    reg                      vfy_ok_r;
    reg                      dis_opt_r;
    reg                      dis_act_r;
    reg                      init_done_r;
    reg  [15:0]              pincfg_r;
    reg  [`PID_I_W-1:0]      irq_stat_r;
    reg  [`PID_I_W-1:0]      irq_mask_r;
    reg  [`PID_I_W-1:0]      ev_nxt;
    reg  [`PID_PINS-1:0]     pin_out_nxt;
    reg  [`PID_PINS-1:0]     pin_oe_n_nxt;
    reg  [31:0]              rdata_nxt;
    reg  [1:0]               pc;
    integer                  k;
    wire                     tck_rise;
    wire                     frame_end;
    wire                     busy;
    wire                     prog_we;
    wire                     prog_clr;
    wire                     chk_clr;
    wire [31:0]              prog_sig;
    wire [31:0]              chk_sig;
    wire [`PID_BUF_W-1:0]    mem_rdata;
    wire [31:0]              ref_sig;

    // ------------------------------------------------------------------
    // Link pin synchronisers and edge detection.
    // ------------------------------------------------------------------
    // Every pin passes two flops; the second stage is examined, and the clock and frame-select pins feed a third flop for edge detection.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tck_s_r  <= 2'b00;
            tms_s_r  <= 2'b00;
            tdi_s_r  <= 2'b00;
            trst_s_r <= 2'b00;
            tck_d_r  <= 1'b0;
            tms_d_r  <= 1'b0;
        end else begin
            tck_s_r  <= {tck_s_r[0], i_tck};
            tms_s_r  <= {tms_s_r[0], i_tms};
            tdi_s_r  <= {tdi_s_r[0], i_tdi};
            trst_s_r <= {trst_s_r[0], i_test_logic_reset_pin};
            tck_d_r  <= tck_s_r[1];
            tms_d_r  <= tms_s_r[1];
        end
    end

    assign tck_rise  = tck_s_r[1] & ~tck_d_r;
    assign frame_end = tms_d_r & ~tms_s_r[1];
    assign o_tdo     = resp_r[`PID_BUF_W-1];

    // ------------------------------------------------------------------
    // Command register and data buffer.
    // ------------------------------------------------------------------
    // A frame shifts 128 data bits then 8 command bits, MSB first.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_r   <= {`PID_FRAME_W{1'b0}};
            cmd_r     <= {`PID_CMD_W{1'b0}};
            buf_r     <= {`PID_BUF_W{1'b0}};
            cmd_vld_r <= 1'b0;
        end else begin
            cmd_vld_r <= 1'b0;
            if (tms_s_r[1] && tck_rise) begin
                shift_r <= {shift_r[`PID_FRAME_W-2:0], tdi_s_r[1]};
            end
            if (frame_end) begin
                cmd_r     <= shift_r[`PID_CMD_W-1:0];                 // RULE15
                buf_r     <= shift_r[`PID_FRAME_W-1:`PID_CMD_W];      // RULE15
                cmd_vld_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Image store and the two signature registers.
    // ------------------------------------------------------------------
    assign busy     = (state_r != ST_IDLE);
    assign prog_we  = cmd_vld_r && (state_r == ST_PROG) && (cmd_r == `PID_C_DATA) && !wr_cnt_r[`PID_AW];
    assign prog_clr = cmd_vld_r && (state_r == ST_IDLE) && (cmd_r == `PID_C_START);
    assign chk_clr  = (state_r == ST_PROG || state_r == ST_IDLE) && cmd_vld_r;
    assign ref_sig  = mode_prog_r ? prog_sig : digest_r;

    pid_store u_store (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_we     (prog_we),
        .i_waddr  (wr_cnt_r[`PID_AW-1:0]),
        .i_wdata  (buf_r),
        .i_raddr  (rd_ptr_r),
        .o_rdata  (mem_rdata)
    );

    // Accumulates alongside the programming writes.
    pid_misr u_prog_misr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clr    (prog_clr),                                         // RULE16
        .i_en     (prog_we),                                          // RULE6
        .i_data   (fold(buf_r)),                                      // RULE5
        .o_sig    (prog_sig)
    );

    // Recomputes over the stored image with the same seed and polynomial.
    pid_misr u_chk_misr (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clr    (chk_clr),                                          // RULE16
        .i_en     (state_r == ST_ACC),
        .i_data   (fold(mem_rdata)),                                  // RULE7
        .o_sig    (chk_sig)
    );

    // ------------------------------------------------------------------
    // Programming and verify sequencer.
    // ------------------------------------------------------------------
    // Info is served in any state and touches no counter.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r      <= ST_IDLE;
            mode_prog_r  <= 1'b0;
            wr_cnt_r     <= {(`PID_AW+1){1'b0}};
            rd_ptr_r     <= {`PID_AW{1'b0}};
            digest_r     <= 32'h0000_0000;
            name_r       <= 32'h0000_0000;
            chksum_r     <= 32'h0000_0000;
            cycles_r     <= 32'h0000_0000;
            programmed_r <= 1'b0;                                     // RULE3
            enabled_r    <= 1'b0;
            vfy_ok_r     <= 1'b0;
            dis_opt_r    <= 1'b0;
            resp_r       <= {`PID_BUF_W{1'b0}};
            ev_nxt       <= {`PID_I_W{1'b0}};
        end else begin
            ev_nxt <= {`PID_I_W{1'b0}};
            if (tms_s_r[1] && tck_rise) begin
                resp_r <= {resp_r[`PID_BUF_W-2:0], 1'b0};
            end
            if (cmd_vld_r && cmd_r == `PID_C_INFO) begin
                resp_r <= {name_r, chksum_r, digest_r, cycles_r};     // RULE10 RULE11 RULE12
                ev_nxt[`PID_I_INFO] <= 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    if (cmd_vld_r && cmd_r == `PID_C_START) begin
                        state_r      <= ST_PROG;
                        enabled_r    <= 1'b0;                         // RULE14
                        programmed_r <= 1'b0;
                        wr_cnt_r     <= {(`PID_AW+1){1'b0}};
                        name_r       <= buf_r[31:0];
                        dis_opt_r    <= buf_r[32];
                        chksum_r     <= 32'h0000_0000;
                    end else if (cmd_vld_r && cmd_r == `PID_C_VERIFY) begin
                        if (programmed_r && !dis_act_r && wr_cnt_r != 0) begin
                            mode_prog_r <= 1'b0;                      // RULE7 RULE8
                            rd_ptr_r    <= {`PID_AW{1'b0}};
                            state_r     <= ST_RD;
                        end else begin
                            ev_nxt[`PID_I_REFUSED] <= 1'b1;           // RULE9
                        end
                    end else if (cmd_vld_r && (cmd_r == `PID_C_DATA || cmd_r == `PID_C_END)) begin
                        ev_nxt[`PID_I_REFUSED] <= 1'b1;
                    end
                end
                ST_PROG: begin
                    if (prog_we) begin
                        wr_cnt_r <= wr_cnt_r + 1'b1;
                        chksum_r <= chksum_r + buf_r[127:96] + buf_r[95:64] + buf_r[63:32] + buf_r[31:0];
                    end else if (cmd_vld_r && cmd_r == `PID_C_END) begin
                        mode_prog_r <= 1'b1;
                        rd_ptr_r    <= {`PID_AW{1'b0}};
                        state_r     <= (wr_cnt_r != 0) ? ST_RD : ST_DONE;
                    end else if (cmd_vld_r && cmd_r != `PID_C_INFO) begin
                        ev_nxt[`PID_I_REFUSED] <= 1'b1;
                    end
                end
                ST_RD: begin
                    state_r <= ST_ACC;
                end
                ST_ACC: begin
                    if ({1'b0, rd_ptr_r} + 1'b1 == wr_cnt_r) begin
                        state_r <= ST_DONE;
                    end else begin
                        rd_ptr_r <= rd_ptr_r + 1'b1;
                        state_r  <= ST_RD;
                    end
                end
                ST_DONE: begin
                    state_r  <= ST_IDLE;
                    vfy_ok_r <= (chk_sig == ref_sig);
                    if (mode_prog_r) begin
                        if (chk_sig == ref_sig && wr_cnt_r != 0) begin
                            digest_r     <= prog_sig;                 // RULE6
                            programmed_r <= 1'b1;
                            enabled_r    <= 1'b1;                     // RULE14
                            cycles_r     <= cycles_r + 1'b1;
                            ev_nxt[`PID_I_PROG_OK] <= 1'b1;
                        end else begin
                            ev_nxt[`PID_I_PROG_ERR] <= 1'b1;          // RULE14
                        end
                    end else begin
                        ev_nxt[`PID_I_VFY_DONE] <= 1'b1;
                        ev_nxt[`PID_I_VFY_BAD]  <= (chk_sig != ref_sig); // RULE7
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Digest-check disable taken once after reset release.
    // ------------------------------------------------------------------
    // Samples dis_opt_r once after reset, which has just cleared it, so the option never acts.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            init_done_r <= 1'b0;
            dis_act_r   <= 1'b0;
        end else if (!init_done_r) begin
            init_done_r <= 1'b1;
            dis_act_r   <= dis_opt_r & ~trst_s_r[1];                  // RULE9
        end
    end

    // ------------------------------------------------------------------
    // Pin isolation and bus gating.
    // ------------------------------------------------------------------
    // Blank parts float; programming follows the per-pin setting.
    always @* begin
        pin_out_nxt  = {`PID_PINS{1'b0}};
        pin_oe_n_nxt = {`PID_PINS{1'b1}};                             // RULE3
        for (k = 0; k < `PID_PINS; k = k + 1) begin
            pc = pincfg_r[2*k +: 2];
            if (busy) begin
                pin_out_nxt[k]  = (pc == 2'b10);                      // RULE4
                pin_oe_n_nxt[k] = !(pc == 2'b01 || pc == 2'b10);      // RULE1 RULE4
            end else if (enabled_r) begin
                pin_out_nxt[k]  = i_fab_out[k];
                pin_oe_n_nxt[k] = i_fab_oe_n[k];
            end
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin_out   <= {`PID_PINS{1'b0}};
            o_pin_oe_n  <= {`PID_PINS{1'b1}};                         // RULE3
            o_fabric_en <= 1'b0;
            o_bus_block <= 1'b1;
        end else begin
            o_pin_out   <= pin_out_nxt;
            o_pin_oe_n  <= pin_oe_n_nxt;
            o_fabric_en <= enabled_r & ~busy;
            o_bus_block <= busy | ~enabled_r;                         // RULE2
        end
    end

    // ------------------------------------------------------------------
    // Register port and interrupts.
    // ------------------------------------------------------------------
    always @* begin
        case (i_addr)
            `PID_A_PINCFG:  rdata_nxt = {16'h0000, pincfg_r};
            `PID_A_STATUS:  rdata_nxt = {26'h000_0000, dis_opt_r, dis_act_r, vfy_ok_r,
                                         programmed_r, enabled_r, busy};
            `PID_A_DIGEST:  rdata_nxt = digest_r;
            `PID_A_CYCLES:  rdata_nxt = cycles_r;
            `PID_A_NAME:    rdata_nxt = name_r;
            `PID_A_CHKSUM:  rdata_nxt = chksum_r;
            `PID_A_IRQSTAT: rdata_nxt = {26'h000_0000, irq_stat_r};
            `PID_A_IRQMASK: rdata_nxt = {26'h000_0000, irq_mask_r};
            default:        rdata_nxt = 32'h0000_0000;
        endcase
    end

    // An interrupt status read clears what it returned; a new event in that cycle survives.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata    <= 32'h0000_0000;
            pincfg_r   <= `PID_PINCFG_RST;
            irq_stat_r <= {`PID_I_W{1'b0}};
            irq_mask_r <= {`PID_I_W{1'b0}};
            o_irq      <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
            if (i_wr && i_addr == `PID_A_PINCFG) begin
                pincfg_r <= i_wdata[15:0];
            end
            if (i_wr && i_addr == `PID_A_IRQMASK) begin
                irq_mask_r <= i_wdata[`PID_I_W-1:0];
            end
            if (i_rd && i_addr == `PID_A_IRQSTAT) begin
                irq_stat_r <= ev_nxt;
            end else begin
                irq_stat_r <= irq_stat_r | ev_nxt;
            end
            o_irq <= |(((i_rd && i_addr == `PID_A_IRQSTAT) ? ev_nxt : (irq_stat_r | ev_nxt)) &
                       ((i_wr && i_addr == `PID_A_IRQMASK) ? i_wdata[`PID_I_W-1:0] : irq_mask_r));
        end
    end
endmodule

// ---- hw/pid_misr.v ----
`timescale 1ns/100ps
`include "pid_regs.vh"
// 32-bit multiple-input signature register, one word folded in per step.
module pid_misr (
    // Clock and reset.
    input  wire        i_clk,
    input  wire        i_resetn,
    // Control and data.
    input  wire        i_clr,
    input  wire        i_en,
    input  wire [31:0] i_data,
    // Signature.
    output reg  [31:0] o_sig
);
    // ------------------------------------------------------------------
    // Signature update.
    // ------------------------------------------------------------------
    // Clear loads the seed; each enable shifts with feedback and mixes data.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sig <= `PID_SEED;
        end else if (i_clr) begin
            o_sig <= `PID_SEED;
        end else if (i_en) begin
            o_sig <= {o_sig[30:0], 1'b0} ^ (o_sig[31] ? `PID_POLY : 32'h0000_0000) ^ i_data;
        end
    end
endmodule

// ---- hw/pid_regs.vh ----
`ifndef PID_REGS_VH
`define PID_REGS_VH
// ----------------------------------------------------------------------
// Register word offsets (byte addresses).
// ----------------------------------------------------------------------
`define PID_A_PINCFG   8'h00
`define PID_A_STATUS   8'h04
`define PID_A_DIGEST   8'h08
`define PID_A_CYCLES   8'h0C
`define PID_A_NAME     8'h10
`define PID_A_CHKSUM   8'h14
`define PID_A_IRQSTAT  8'h18
`define PID_A_IRQMASK  8'h1C
// ----------------------------------------------------------------------
// Status bit positions.
// ----------------------------------------------------------------------
`define PID_S_BUSY     0
`define PID_S_ENABLED  1
`define PID_S_PROGRAMD 2
`define PID_S_VFY_OK   3
`define PID_S_DIS_ACT  4
`define PID_S_DIS_OPT  5
// ----------------------------------------------------------------------
// Interrupt bit positions.
// ----------------------------------------------------------------------
`define PID_I_PROG_OK  0
`define PID_I_PROG_ERR 1
`define PID_I_VFY_DONE 2
`define PID_I_VFY_BAD  3
`define PID_I_INFO     4
`define PID_I_REFUSED  5
`define PID_I_W        6
// ----------------------------------------------------------------------
// Link commands and sizes.
// ----------------------------------------------------------------------
`define PID_C_START    8'h01
`define PID_C_DATA     8'h02
`define PID_C_END      8'h03
`define PID_C_VERIFY   8'h04
`define PID_C_INFO     8'h05
`define PID_CMD_W      8
`define PID_BUF_W      128
`define PID_FRAME_W    136
`define PID_AW         4
`define PID_DEPTH      16
`define PID_PINS       8
// ----------------------------------------------------------------------
// Signature register seed and feedback polynomial; pin setting reset value.
// ----------------------------------------------------------------------
`define PID_SEED       32'hFFFF_FFFF
`define PID_POLY       32'h04C1_1DB7
`define PID_PINCFG_RST 16'h0000
`endif

// ---- hw/pid_store.v ----
`timescale 1ns/100ps
`include "pid_regs.vh"
// Image store: one write port, one read port with registered data.
module pid_store (
    // Clock and reset.
    input  wire                 i_clk,
    input  wire                 i_resetn,
    // Write port.
    input  wire                 i_we,
    input  wire [`PID_AW-1:0]   i_waddr,
    input  wire [`PID_BUF_W-1:0] i_wdata,
    // Read port.
    input  wire [`PID_AW-1:0]   i_raddr,
    output reg  [`PID_BUF_W-1:0] o_rdata
);
    reg [`PID_BUF_W-1:0] mem [0:`PID_DEPTH-1];

    // ------------------------------------------------------------------
    // Storage array.
    // ------------------------------------------------------------------
    // The array itself holds no reset; only the read register does.
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Read data leave through a register, one cycle after the address.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= {`PID_BUF_W{1'b0}};
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ---- verification/pid_ctrl_monitor.sv ----
`timescale 1ns/100ps
module pid_ctrl_monitor (
    // Watched ports.
    input wire       i_clk,
    input wire       i_resetn,
    input wire       i_tms,
    input wire       i_wr,
    input wire [7:0] i_fab_oe_n,
    input wire [7:0] o_pin_oe_n,
    input wire       o_tdo,
    input wire       o_fabric_en,
    input wire       o_bus_block,
    input wire       o_irq
);
    logic [7:0] idle_r;
    // Counts cycles since the frame select pin was last high.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            idle_r <= 8'h00;
        else if (i_tms)
            idle_r <= 8'h00;
        else if (idle_r != 8'hFF)
            idle_r <= idle_r + 8'h01;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_gate; !o_fabric_en |-> o_bus_block; endproperty
    a_gate: assert property (p_gate) else $error("Bus open.");
    property p_blank; $rose(i_resetn) |-> o_pin_oe_n == 8'hFF && !o_fabric_en; endproperty
    a_blank: assert property (p_blank) else $error("Pins driven.");
    property p_quiet; $rose(i_resetn) |-> !o_irq [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("Early event.");
    property p_tdo; idle_r > 8'd100 |-> $stable(o_tdo); endproperty
    a_tdo: assert property (p_tdo) else $error("Reply moved.");
    property p_rise; $rose(o_fabric_en) |-> idle_r > 8'd2; endproperty
    a_rise: assert property (p_rise) else $error("Early enable.");
    property p_fall; $fell(o_fabric_en) |-> idle_r > 8'd2; endproperty
    a_fall: assert property (p_fall) else $error("Early disable.");
    property p_follow; o_fabric_en && $past(o_fabric_en, 2) && $stable(i_fab_oe_n) |-> o_pin_oe_n == i_fab_oe_n; endproperty
    a_follow: assert property (p_follow) else $error("Pins not fabric.");
    property p_irq; $rose(o_irq) && !$past(i_wr) && !$past(i_wr, 2) |-> idle_r > 8'd2; endproperty
    a_irq: assert property (p_irq) else $error("Stray event.");
endmodule
bind pid_ctrl pid_ctrl_monitor i_mon (.i_clk, .i_resetn, .i_tms, .i_wr, .i_fab_oe_n, .o_pin_oe_n, .o_tdo,
    .o_fabric_en, .o_bus_block, .o_irq);

// ---- verification/pid_prog_model.sv ----
`timescale 1ns/100ps
module pid_prog_model (
    // Link pins toward the device.
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    // Reply pin.
    input  wire  i_tdo
);
    int verifies = 0;
    // Link clock stands still and data rests at its pull-up level.
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b0;
        o_tdi = 1'b1;
    end
    // Shifts one frame MSB first and keeps the first 128 reply bits.
    task automatic frame(input [7:0] cmd, input [127:0] d, output [127:0] rsp);
        logic [135:0] f;
        f = {d, cmd};
        if (cmd == 8'h04)
            verifies++;
        o_tms = 1'b1;
        for (int i = 135; i >= 0; i--) begin
            o_tdi = f[i];
            #62.5;
            if (i >= 8)
                rsp[i-8] = i_tdo;
            o_tck = 1'b1;
            #62.5;
            o_tck = 1'b0;
        end
        o_tms = 1'b0;
        o_tdi = 1'b1;
    endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`include "pid_regs.vh"
module testbench;
    logic         i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, tck, tms, tdi, o_tdo;
    logic         o_fabric_en, o_bus_block, o_irq;
    logic [7:0]   i_addr = 8'h00, i_fab_out = 8'hA5, i_fab_oe_n = 8'h0F, o_pin_out, o_pin_oe_n;
    logic [31:0]  i_wdata = 32'h0000_0000, o_rdata, sum = 32'h0000_0000, dig;
    logic [127:0] rsp, w0 = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978, w1 = 128'hFFFF_0000_1357_9BDF_8000_0001_2468_ACE0;
    int           mismatches = 0, comparisons = 0;
    initial forever #2 i_clk = ~i_clk;
    pid_ctrl i_dut (.i_clk, .i_resetn, .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_test_logic_reset_pin(1'b0),
        .o_tdo, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fab_out, .i_fab_oe_n, .o_pin_out, .o_pin_oe_n,
        .o_fabric_en, .o_bus_block, .o_irq);
    pid_prog_model i_prog (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo));
    task automatic chk(input [127:0] seen, input [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic go(input [7:0] c, input [127:0] d);
        i_prog.frame(c, d, rsp);
        repeat (60) @(posedge i_clk);
    endtask
    function automatic [31:0] step(input [31:0] s, input [127:0] w);
        step = {s[30:0], 1'b0} ^ (s[31] ? `PID_POLY : 32'h0000_0000) ^ w[127:96] ^ w[95:64] ^ w[63:32] ^ w[31:0];
    endfunction
    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hung run short.
    initial begin
        #300000;
        mismatches++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        dig = step(step(`PID_SEED, w0), w1);
        for (int i = 0; i < 4; i++)
            sum = sum + w0[32*i+:32] + w1[32*i+:32];
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        chk({o_pin_oe_n, o_bus_block, o_fabric_en}, {8'hFF, 2'b10});
        rd(`PID_A_STATUS, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        wr(`PID_A_IRQMASK, 32'h0000_003F);
        go(`PID_C_VERIFY, 128'h0);
        chk(o_irq, 1'b1);
        rd(`PID_A_IRQSTAT, 32'h0000_0020);
        rd(`PID_A_IRQSTAT, 32'h0000_0000);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1'b0);
        wr(`PID_A_PINCFG, 32'h0000_0006);
        go(`PID_C_START, {96'h0, 32'h1234_5678});
        rd(`PID_A_STATUS, 32'h0000_0001);
        chk({o_pin_oe_n, o_pin_out[1:0], o_bus_block, o_fabric_en}, {8'hFC, 4'b0110});
        go(`PID_C_DATA, w0);
        go(`PID_C_DATA, w1);
        go(`PID_C_END, 128'h0);
        rd(`PID_A_DIGEST, dig);
        rd(`PID_A_STATUS, 32'h0000_000E);
        rd(`PID_A_IRQSTAT, 32'h0000_0001);
        go(`PID_C_INFO, 128'h0);
        go(`PID_C_INFO, 128'h0);
        chk(rsp, {32'h1234_5678, sum, dig, 32'h0000_0001});
        go(`PID_C_VERIFY, 128'h0);
        chk(rsp, {32'h1234_5678, sum, dig, 32'h0000_0001});
        rd(`PID_A_CYCLES, 32'h0000_0001);
        rd(`PID_A_STATUS, 32'h0000_000E);
        rd(`PID_A_IRQSTAT, 32'h0000_0014);
        chk({o_pin_oe_n, o_pin_out, o_bus_block, o_fabric_en}, {i_fab_oe_n, i_fab_out, 2'b01});
        chk(i_prog.verifies, 2);
        go(`PID_C_START, 128'h0);
        chk({o_pin_oe_n, o_bus_block, o_fabric_en}, {8'hFC, 2'b10});
        report_and_stop();
    end
endmodule
